// [design/usart_pkg.sv]
package usart_pkg;

  // register byte offsets
  localparam logic [7:0] OFS_DATA   = 8'h00;
  localparam logic [7:0] OFS_CSR_A  = 8'h04;
  localparam logic [7:0] OFS_CSR_B  = 8'h08;
  localparam logic [7:0] OFS_FORMAT = 8'h0C;
  localparam logic [7:0] OFS_BAUD   = 8'h10;

  // control_status_a bits
  localparam int A_RX_COMPLETE = 7;
  localparam int A_TX_COMPLETE = 6;
  localparam int A_TX_EMPTY    = 5;
  localparam int A_FRAME_ERR   = 4;
  localparam int A_OVERRUN     = 3;
  localparam int A_PARITY_ERR  = 2;

  // control_status_b bits
  localparam int B_RX_IRQ_EN    = 7;
  localparam int B_TXC_IRQ_EN   = 6;
  localparam int B_EMPTY_IRQ_EN = 5;
  localparam int B_RX_EN        = 4;
  localparam int B_TX_EN        = 3;
  localparam int B_SIZE_HI      = 2;
  localparam int B_RX_NINTH     = 1;
  localparam int B_TX_NINTH     = 0;

  // format register bits
  localparam int F_SYNC_MODE  = 6;
  localparam int F_PARITY_EN  = 5;
  localparam int F_PARITY_ODD = 4;
  localparam int F_TWO_STOP   = 3;
  localparam int F_SIZE_LO    = 1;

  localparam logic [2:0] SIZE_NINE_BITS = 3'h7;
  localparam logic [3:0] SIZE_BASE_BITS = 4'h5;

  // receive buffer entry layout
  localparam int ENT_WIDTH = 12;
  localparam int ENT_DOR   = 11;
  localparam int ENT_FE    = 10;
  localparam int ENT_PE    = 9;
  localparam int RX_DEPTH  = 2;

  localparam logic [11:0] BAUD_RESET = 12'h000;

  typedef enum logic [2:0] {
    TX_IDLE, TX_START, TX_DATA, TX_PARITY, TX_STOP1, TX_STOP2
  } tx_state_t;

  typedef enum logic [2:0] {
    RX_IDLE, RX_START, RX_DATA, RX_PARITY, RX_STOP
  } rx_state_t;

endpackage : usart_pkg

// [design/usart_rx_fifo.sv]
`timescale 1ns/1ns
`default_nettype none

module usart_rx_fifo
  import usart_pkg::*;
#(
  parameter int WIDTH = ENT_WIDTH,
  parameter int DEPTH = RX_DEPTH
) (
  // clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  // control
  input  wire logic             flush,
  input  wire logic             push,
  input  wire logic [WIDTH-1:0] push_data,
  input  wire logic             pop,
  // status
  output logic      [WIDTH-1:0] head,
  output logic                  valid,
  output logic                  full
);

  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [CW-1:0]               count;
  } fifo_state_t;

  fifo_state_t s;
  fifo_state_t n;
  logic        do_pop;
  logic [CW-1:0] wr_idx;

  assign head  = s.mem[0];
  assign valid = (s.count != '0);
  assign full  = (s.count == CW'(DEPTH));

  always_comb begin
    n = s;
    do_pop = pop && valid;
    wr_idx = s.count;
    // head always sits at entry 0, so a pop shifts the rest down
    if (do_pop) begin
      for (int i = 0; i < DEPTH - 1; i++) begin
        n.mem[i] = s.mem[i + 1];
      end
      n.count = s.count - CW'(1);
      wr_idx = s.count - CW'(1);
    end
    if (push && (!full || do_pop)) begin
      n.mem[wr_idx] = push_data;
      n.count = n.count + CW'(1);
    end
    if (flush) begin
      n.count = '0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

endmodule : usart_rx_fifo

`default_nettype wire

// [design/usart_buffer_flag_logic.sv]
// The register addresses and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none

module usart_buffer_flag_logic
  import usart_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  // apb slave
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // interrupt requests and acknowledge
  output logic                   tx_buffer_empty_irq,
  output logic                   tx_complete_irq,
  output logic                   rx_complete_irq,
  input  wire logic              tx_complete_irq_ack,
  // serial pins
  output logic                   serial_out_pin,
  output logic                   serial_out_oe,
  input  wire logic              serial_in_pin,
  output logic                   serial_in_taken,
  input  wire logic              transfer_clock_pin
);

  typedef struct packed {
    logic             pready;
    logic             pslverr;
    logic [31:0]      prdata;
    logic [7:0]       ctl_b;
    logic [6:0]       format;
    logic [11:0]      baud;
    logic [8:0]       tx_buf;
    logic             tx_buf_full;
    logic             tx_complete_flag;
    logic             tx_active;
    tx_state_t        tx_state;
    logic [3:0]       tx_cnt;
    logic [8:0]       tx_shift;
    logic [11:0]      tx_div;
    logic             tx_par;
    logic             tx_line;
    logic [1:0]       rxd_sync;
    logic [2:0]       xck_sync;
    rx_state_t        rx_state;
    logic [3:0]       rx_cnt;
    logic [8:0]       rx_shift;
    logic [11:0]      rx_div;
    logic             rx_par;
    logic             rx_pe;
    logic [ENT_WIDTH-1:0] rx_hold;
    logic             rx_pending;
    logic             rx_ovr;
    logic             irq_empty;
    logic             irq_txc;
    logic             irq_rxc;
  } state_t;

  state_t s;
  state_t n;

  logic [ENT_WIDTH-1:0] fifo_head;
  logic [ENT_WIDTH-1:0] fifo_data;
  logic                 fifo_valid;
  logic                 fifo_full;
  logic                 fifo_push;
  logic                 fifo_pop;
  logic                 fifo_flush;
  logic [2:0]           size_code;
  logic [3:0]           nbits;
  logic                 sync_mode;
  logic                 par_en;
  logic                 par_odd;
  logic                 rxd;
  logic                 xck_rise;
  logic                 xck_fall;
  logic                 tx_tick;
  logic                 rx_tick;
  logic                 first_access;
  logic                 done;
  logic                 hit;
  logic                 data_wr;
  logic [ENT_WIDTH-1:0] head_q;
  logic [ENT_WIDTH-1:0] new_entry;

  usart_rx_fifo #(
    .WIDTH (ENT_WIDTH),
    .DEPTH (RX_DEPTH)
  ) u_rx_fifo (
    .pclk      (pclk),
    .presetn   (presetn),
    .flush     (fifo_flush),
    .push      (fifo_push),
    .push_data (fifo_data),
    .pop       (fifo_pop),
    .head      (fifo_head),
    .valid     (fifo_valid),
    .full      (fifo_full)
  );

  assign prdata              = s.prdata;
  assign pready              = s.pready;
  assign pslverr             = s.pslverr;
  assign tx_buffer_empty_irq = s.irq_empty;
  assign tx_complete_irq     = s.irq_txc;
  assign rx_complete_irq     = s.irq_rxc;
  assign serial_out_pin      = s.tx_line;
  assign serial_out_oe       = s.tx_active;
  assign serial_in_taken     = s.ctl_b[B_RX_EN];

  always_comb begin
    n = s;
    fifo_push = 1'b0;
    fifo_pop = 1'b0;
    fifo_flush = 1'b0;
    fifo_data = '0;
    new_entry = '0;
    data_wr = 1'b0;

    // format fields serve transmitter and receiver alike
    size_code = {s.ctl_b[B_SIZE_HI], s.format[F_SIZE_LO +: 2]};
    nbits = (size_code == SIZE_NINE_BITS) ? 4'h9
          : SIZE_BASE_BITS + {2'h0, size_code[1:0]};
    sync_mode = s.format[F_SYNC_MODE];
    par_en = s.format[F_PARITY_EN];
    par_odd = s.format[F_PARITY_ODD];

    // pin synchronisers; stage 0 feeds stage 1 only
    n.rxd_sync = {s.rxd_sync[0], serial_in_pin};
    n.xck_sync = {s.xck_sync[1:0], transfer_clock_pin};
    rxd = s.rxd_sync[1];
    xck_rise = s.xck_sync[1] && !s.xck_sync[2];
    xck_fall = !s.xck_sync[1] && s.xck_sync[2];
    tx_tick = sync_mode ? xck_fall : (s.tx_div == '0);
    rx_tick = sync_mode ? xck_rise : (s.rx_div == '0);
    head_q = fifo_valid ? fifo_head : '0;

    // apb: one wait state, answer registered
    first_access = psel && penable && !s.pready;
    done = psel && penable && s.pready;
    hit = (paddr == ADDR_W'(OFS_DATA)) || (paddr == ADDR_W'(OFS_CSR_A))
       || (paddr == ADDR_W'(OFS_CSR_B)) || (paddr == ADDR_W'(OFS_FORMAT))
       || (paddr == ADDR_W'(OFS_BAUD));
    n.pready = first_access;
    n.pslverr = first_access && !hit;
    if (first_access) begin
      n.prdata = '0;
      if (paddr == ADDR_W'(OFS_DATA)) begin
        n.prdata[7:0] = head_q[7:0];
      end else if (paddr == ADDR_W'(OFS_CSR_A)) begin
        n.prdata[A_RX_COMPLETE] = fifo_valid;
        n.prdata[A_TX_COMPLETE] = s.tx_complete_flag;
        n.prdata[A_TX_EMPTY] = !s.tx_buf_full;
        n.prdata[A_FRAME_ERR] = head_q[ENT_FE];
        n.prdata[A_OVERRUN] = head_q[ENT_DOR];
        n.prdata[A_PARITY_ERR] = head_q[ENT_PE];
      end else if (paddr == ADDR_W'(OFS_CSR_B)) begin
        n.prdata[7:0] = s.ctl_b;
        n.prdata[B_RX_NINTH] = head_q[8];
      end else if (paddr == ADDR_W'(OFS_FORMAT)) begin
        n.prdata[6:0] = s.format;
      end else if (paddr == ADDR_W'(OFS_BAUD)) begin
        n.prdata[11:0] = s.baud;
      end
    end
    if (done && hit && pwrite) begin
      if (paddr == ADDR_W'(OFS_DATA)) begin
        // the ninth bit is taken from control b at this moment
        n.tx_buf = {s.ctl_b[B_TX_NINTH], pwdata[7:0]};
        n.tx_buf_full = 1'b1;
        data_wr = 1'b1;
      end else if (paddr == ADDR_W'(OFS_CSR_A)) begin
        // empty and error bits are read-only here
        if (pwdata[A_TX_COMPLETE]) begin
          n.tx_complete_flag = 1'b0;
        end
      end else if (paddr == ADDR_W'(OFS_CSR_B)) begin
        n.ctl_b = pwdata[7:0];
      end else if (paddr == ADDR_W'(OFS_FORMAT)) begin
        n.format = pwdata[6:0];
      end else if (paddr == ADDR_W'(OFS_BAUD)) begin
        n.baud = pwdata[11:0];
      end
    end
    if (done && !pwrite && paddr == ADDR_W'(OFS_DATA)) begin
      fifo_pop = 1'b1;
    end
    if (tx_complete_irq_ack) begin
      n.tx_complete_flag = 1'b0;
    end

    // transmitter
    if (s.ctl_b[B_TX_EN]) begin
      n.tx_active = 1'b1;
    end else if (!s.tx_buf_full && s.tx_state == TX_IDLE) begin
      n.tx_active = 1'b0;
    end
    if (s.tx_state == TX_IDLE || s.tx_div == '0) begin
      n.tx_div = s.baud;
    end else begin
      n.tx_div = s.tx_div - 12'h001;
    end
    if (tx_tick) begin
      case (s.tx_state)
        TX_START: begin
          n.tx_line = s.tx_shift[0];
          n.tx_par = s.tx_shift[0];
          n.tx_shift = s.tx_shift >> 1;
          n.tx_cnt = 4'h1;
          n.tx_state = TX_DATA;
        end
        TX_DATA: begin
          if (s.tx_cnt == nbits) begin
            if (par_en) begin
              n.tx_line = s.tx_par ^ par_odd;
              n.tx_state = TX_PARITY;
            end else begin
              n.tx_line = 1'b1;
              n.tx_state = TX_STOP1;
            end
          end else begin
            n.tx_line = s.tx_shift[0];
            n.tx_par = s.tx_par ^ s.tx_shift[0];
            n.tx_shift = s.tx_shift >> 1;
            n.tx_cnt = s.tx_cnt + 4'h1;
          end
        end
        TX_PARITY: begin
          n.tx_line = 1'b1;
          n.tx_state = TX_STOP1;
        end
        TX_STOP1: begin
          n.tx_state = s.format[F_TWO_STOP] ? TX_STOP2 : TX_IDLE;
        end
        TX_STOP2: begin
          n.tx_state = TX_IDLE;
        end
        default: begin
          n.tx_state = TX_IDLE;
        end
      endcase
      if (s.tx_state != TX_IDLE && n.tx_state == TX_IDLE
          && !s.tx_buf_full) begin
        n.tx_complete_flag = 1'b1;
      end
    end
    // load straight from idle or right after the last stop bit
    if (n.tx_state == TX_IDLE && s.tx_active && s.tx_buf_full) begin
      n.tx_shift = s.tx_buf;
      n.tx_buf_full = data_wr;
      n.tx_state = TX_START;
      n.tx_line = 1'b0;
    end else if (n.tx_state == TX_IDLE) begin
      n.tx_line = 1'b1;
    end

    // receiver
    if (!s.ctl_b[B_RX_EN]) begin
      // disabling is immediate and drops everything unread
      n.rx_state = RX_IDLE;
      n.rx_pending = 1'b0;
      n.rx_ovr = 1'b0;
      fifo_flush = 1'b1;
    end else begin
      n.rx_div = (s.rx_div == '0) ? s.baud : s.rx_div - 12'h001;
      new_entry = {s.rx_ovr, !rxd, s.rx_pe, s.rx_shift};
      case (s.rx_state)
        RX_IDLE: begin
          if (!rxd && (!sync_mode || xck_rise)) begin
            if (s.rx_pending && fifo_full) begin
              n.rx_ovr = 1'b1;
            end
            n.rx_shift = '0;
            n.rx_par = 1'b0;
            n.rx_pe = 1'b0;
            n.rx_cnt = '0;
            n.rx_div = {1'b0, s.baud[11:1]};
            n.rx_state = sync_mode ? RX_DATA : RX_START;
          end
        end
        RX_START: begin
          // mid-bit recheck rejects glitches as start bits
          if (s.rx_div == '0) begin
            n.rx_state = rxd ? RX_IDLE : RX_DATA;
          end
        end
        RX_DATA: begin
          if (rx_tick) begin
            n.rx_shift[s.rx_cnt] = rxd;
            n.rx_par = s.rx_par ^ rxd;
            n.rx_cnt = s.rx_cnt + 4'h1;
            if (s.rx_cnt == nbits - 4'h1) begin
              n.rx_state = par_en ? RX_PARITY : RX_STOP;
            end
          end
        end
        RX_PARITY: begin
          if (rx_tick) begin
            n.rx_pe = s.rx_par ^ rxd ^ par_odd;
            n.rx_state = RX_STOP;
          end
        end
        RX_STOP: begin
          // only the first stop bit is looked at
          if (rx_tick) begin
            n.rx_state = RX_IDLE;
            if (!s.rx_pending && !fifo_full) begin
              fifo_push = 1'b1;
              fifo_data = new_entry;
              n.rx_ovr = 1'b0;
            end else if (!s.rx_pending) begin
              n.rx_hold = new_entry;
              n.rx_pending = 1'b1;
            end
          end
        end
        default: begin
          n.rx_state = RX_IDLE;
        end
      endcase
      if (s.rx_pending && !fifo_full) begin
        fifo_push = 1'b1;
        fifo_data = s.rx_hold;
        fifo_data[ENT_DOR] = s.rx_ovr;
        n.rx_pending = 1'b0;
        n.rx_ovr = 1'b0;
      end
    end

    n.irq_empty = s.ctl_b[B_EMPTY_IRQ_EN] && !n.tx_buf_full;
    n.irq_txc = s.ctl_b[B_TXC_IRQ_EN] && n.tx_complete_flag;
    n.irq_rxc = s.ctl_b[B_RX_IRQ_EN] && fifo_valid;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
      s.tx_line <= 1'b1;
      s.baud <= BAUD_RESET;
    end else begin
      s <= n;
    end
  end

endmodule : usart_buffer_flag_logic

`default_nettype wire

// [verification/usart_buffer_flag_logic_monitor.sv]
`timescale 1ns/1ns
`default_nettype none

module usart_buffer_flag_logic_monitor
  import usart_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  // apb
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  // requests and pins
  input wire logic              tx_buffer_empty_irq,
  input wire logic              tx_complete_irq,
  input wire logic              tx_complete_irq_ack,
  input wire logic              serial_out_pin,
  input wire logic              serial_out_oe,
  input wire logic              serial_in_taken
);
  logic done;
  logic bwr;
  assign done = psel && penable && pready;
  assign bwr = done && pwrite && paddr == OFS_CSR_B;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  AST_DATA_CLEARS_EMPTY: assert property (
    done && pwrite && paddr == OFS_DATA && tx_buffer_empty_irq
    |-> ##[1:2] !tx_buffer_empty_irq) else $error("empty request stayed");
  AST_ACK_CLEARS: assert property (
    tx_complete_irq && tx_complete_irq_ack |-> ##2 !tx_complete_irq)
    else $error("complete request not cleared by ack");
  AST_COMPLETE_AFTER_STOP: assert property (
    $rose(tx_complete_irq) |-> serial_out_pin && $past(serial_out_pin, 2))
    else $error("complete request without stop bit");
  AST_RELEASE_AT_IDLE: assert property (
    $fell(serial_out_oe) |-> serial_out_pin && $past(serial_out_pin, 2))
    else $error("output released mid frame");
  AST_RELEASED_HIGH: assert property (
    !serial_out_oe |-> serial_out_pin) else $error("released line not idle");
  AST_TAKE_ON: assert property (
    bwr && pwdata[B_RX_EN] |-> ##[1:2] serial_in_taken)
    else $error("input pin not taken");
  AST_TAKE_OFF: assert property (
    bwr && !pwdata[B_RX_EN] |-> ##[1:2] !serial_in_taken)
    else $error("input pin not returned");
  AST_TAKE_CAUSE: assert property (
    $changed(serial_in_taken) |-> $past(bwr) || $past(bwr, 2))
    else $error("pin ownership changed without write");
  AST_UPPER_ZERO: assert property (
    done && !pwrite && paddr == OFS_DATA |-> prdata[31:8] == 24'h000000)
    else $error("data read upper bits set");
endmodule : usart_buffer_flag_logic_monitor

bind usart_buffer_flag_logic usart_buffer_flag_logic_monitor #(
  .ADDR_W(ADDR_W)
) mon (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .tx_buffer_empty_irq(tx_buffer_empty_irq),
  .tx_complete_irq(tx_complete_irq),
  .tx_complete_irq_ack(tx_complete_irq_ack),
  .serial_out_pin(serial_out_pin), .serial_out_oe(serial_out_oe),
  .serial_in_taken(serial_in_taken)
);

`default_nettype wire

// [verification/serial_node.sv]
`timescale 1ns/1ns
`default_nettype none

module serial_node #(
  parameter int BT = 4
) (
  // clock
  input  wire logic pclk,
  // serial lines
  input  wire logic line_in,
  output logic      line_out,
  // transfer clock, still between frames
  output logic      xck
);
  int         nbits = 8;
  logic [9:0] got[$];

  initial line_out = 1'b1;
  initial xck = 1'b0;

  // mid-bit sampling of data plus the next bit, parity or stop
  always begin : rx_side
    logic [9:0] w;
    @(negedge line_in);
    w = 10'h000;
    repeat (BT / 2) @(posedge pclk);
    for (int i = 0; i <= nbits; i++) begin
      repeat (BT) @(posedge pclk);
      w[i] = line_in;
    end
    got.push_back(w);
  end

  // start, data lsb first, one stop; the line rests high after
  task automatic send(input logic [8:0] d);
    for (int i = -1; i <= nbits; i++) begin
      @(posedge pclk);
      line_out <= (i < 0) ? 1'b0 : (i == nbits) ? 1'b1 : d[i];
      repeat (BT - 1) @(posedge pclk);
    end
  endtask : send

  // synchronous frame: data changes with clock low, clock rises mid-bit
  task automatic send_sync(input logic [8:0] d);
    for (int i = -1; i <= nbits; i++) begin
      @(posedge pclk);
      line_out <= (i < 0) ? 1'b0 : (i == nbits) ? 1'b1 : d[i];
      xck <= 1'b0;
      repeat (BT / 2) @(posedge pclk);
      xck <= 1'b1;
      repeat (BT / 2 - 1) @(posedge pclk);
    end
    @(posedge pclk);
    xck <= 1'b0;
  endtask : send_sync
endmodule : serial_node

`default_nettype wire

// [verification/usart_buffer_flag_logic_tb.sv]
`timescale 1ns/1ns
`default_nettype none

module usart_buffer_flag_logic_tb;
  import usart_pkg::*;
  localparam int BT = 4;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic        ack = 1'b0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        empty_irq;
  logic        txc_irq;
  logic        rxc_irq;
  logic        tx_pin;
  logic        oe;
  logic        rx_pin;
  logic        taken;
  logic        tx_wire;
  logic        xck;
  logic [31:0] rd;
  logic        err;
  int          err_total = 0;
  int          comparisons = 0;

  always #10 pclk = ~pclk;
  // released line is pulled high
  assign tx_wire = oe ? tx_pin : 1'b1;

  usart_buffer_flag_logic #(.ADDR_W(8)) uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .tx_buffer_empty_irq(empty_irq),
    .tx_complete_irq(txc_irq), .rx_complete_irq(rxc_irq),
    .tx_complete_irq_ack(ack), .serial_out_pin(tx_pin),
    .serial_out_oe(oe), .serial_in_pin(rx_pin),
    .serial_in_taken(taken), .transfer_clock_pin(xck)
  );
  serial_node #(.BT(BT)) node (
    .pclk(pclk), .line_in(tx_wire), .line_out(rx_pin), .xck(xck)
  );

  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : print_verdict

  task automatic chk(input string s, input logic [31:0] e,
                     input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", s, e, g);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 20) begin
      err_total++;
      print_verdict();
    end
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rdm(input logic [7:0] a, input logic [31:0] m,
                     input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk($sformatf("reg %h", a), e, rd & m);
  endtask : rdm

  // bounded wait; frames take 36 to 44 cycles here
  task automatic wait_lv(ref logic s, input logic v);
    int k;
    k = 0;
    while (s !== v && k < 3000) begin
      @(posedge pclk);
      k++;
    end
    if (k >= 3000) begin
      err_total++;
      print_verdict();
    end
  endtask : wait_lv

  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rdm(OFS_CSR_A, 32'hFF, 32'h20);
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped", 32'h1, 32'(err));
    wr(OFS_BAUD, 32'(BT - 1));
    wr(OFS_FORMAT, 32'h06);
    wr(OFS_CSR_B, 32'hF8);
    repeat (2) @(posedge pclk);
    chk("taken", 32'h1, 32'(taken));
    chk("empty irq", 32'h1, 32'(empty_irq));
    $display("test setup done");
    wr(OFS_DATA, 32'hA5);
    wr(OFS_DATA, 32'h3C);
    repeat (2) @(posedge pclk);
    chk("empty irq", 32'h0, 32'(empty_irq));
    wait_lv(txc_irq, 1'b1);
    chk("frame", 32'h1A5, 32'(node.got.pop_front()));
    chk("frame", 32'h13C, 32'(node.got.pop_front()));
    @(posedge pclk);
    ack <= 1'b1;
    @(posedge pclk);
    ack <= 1'b0;
    repeat (2) @(posedge pclk);
    chk("txc irq", 32'h0, 32'(txc_irq));
    $display("test transmit done");
    for (int m = 0; m < 2; m++) begin
      wr(OFS_CSR_A, 32'h40);
      rdm(OFS_CSR_A, 32'h40, 32'h0);
      wr(OFS_FORMAT, 32'h26 | 32'(m << 4));
      wr(OFS_DATA, 32'h07);
      wait_lv(txc_irq, 1'b1);
      chk("parity", m ? 32'h007 : 32'h107, 32'(node.got.pop_front()));
    end
    wr(OFS_FORMAT, 32'h06);
    wr(OFS_CSR_A, 32'h40);
    wr(OFS_DATA, 32'h5A);
    wr(OFS_CSR_B, 32'hF0);
    chk("oe", 32'h1, 32'(oe));
    wait_lv(oe, 1'b0);
    chk("frame", 32'h15A, 32'(node.got.pop_front()));
    $display("test parity and disable done");
    node.nbits = 9;
    wr(OFS_CSR_A, 32'h40);
    wr(OFS_CSR_B, 32'hFD);
    wr(OFS_DATA, 32'h55);
    wait_lv(txc_irq, 1'b1);
    chk("frame", 32'h355, 32'(node.got.pop_front()));
    node.send(9'h1AB);
    node.send(9'h034);
    wait_lv(rxc_irq, 1'b1);
    rdm(OFS_CSR_A, 32'h80, 32'h80);
    rdm(OFS_CSR_B, 32'h02, 32'h02);
    rdm(OFS_DATA, 32'hFFFFFFFF, 32'hAB);
    rdm(OFS_CSR_B, 32'h02, 32'h00);
    rdm(OFS_DATA, 32'hFFFFFFFF, 32'h34);
    rdm(OFS_CSR_A, 32'h80, 32'h00);
    $display("test nine bit done");
    node.nbits = 7;
    wr(OFS_CSR_B, 32'hF8);
    wr(OFS_FORMAT, 32'h04);
    node.send(9'h0FF);
    wait_lv(rxc_irq, 1'b1);
    rdm(OFS_DATA, 32'hFFFFFFFF, 32'h7F);
    node.nbits = 8;
    wr(OFS_FORMAT, 32'h46);
    node.send_sync(9'h0C3);
    wait_lv(rxc_irq, 1'b1);
    rdm(OFS_DATA, 32'hFFFFFFFF, 32'hC3);
    wr(OFS_CSR_B, 32'h48);
    repeat (2) @(posedge pclk);
    chk("taken", 32'h0, 32'(taken));
    chk("empty irq", 32'h0, 32'(empty_irq));
    $display("test receive done");
    print_verdict();
  end
endmodule : usart_buffer_flag_logic_tb

`default_nettype wire
